// [rtl/isa_pkg.sv]
// Constants and types for the two-wire register and RAM access block.
// Function
// - 64-byte RAM kept while on backup supply.
// - One control byte 1101111X reaches both areas.
// - Calendar at 0x00-0x1F, RAM at 0x20-0x5F.
// - RAM access proceeds during calendar internal update.
// - Reset leaves RAM contents untouched, undefined.
// - No serial access while on backup supply.
// - Byte write: acknowledge, load pointer, store data.
// - Address above 0x5F: no acknowledge, no store.
// - After byte write pointer is next location.
// - Each written byte acknowledged, stored, pointer incremented.
// - Unlimited bytes per write until stop.
// - Write pointer wraps 0x1F->0x00, 0x5F->0x20.
// - Current-address read returns last location plus one.
// - Read: acknowledge control byte, send one byte.
// - Pointer set before repeated start ends write.
// - After random read pointer is next location.
// - Master acknowledge requests next byte, pointer increments.
// - Read pointer wraps 0x1F->0x00, 0x5F->0x20.
// - Unimplemented calendar bits read as zero.
package isa_pkg;

    localparam logic [6:0] SLAVE_ID  = 7'h6F;
    localparam logic [6:0] CAL_FIRST = 7'h00;
    localparam logic [6:0] CAL_LAST  = 7'h1F;
    localparam logic [6:0] RAM_FIRST = 7'h20;
    localparam logic [6:0] RAM_LAST  = 7'h5F;
    localparam logic [6:0] PTR_RESET = 7'h00;
    localparam int         RAM_DEPTH = 64;
    localparam int         RAM_AW    = 6;
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_LAST  = 4'h7;
    localparam logic [3:0] ACK_SLOT  = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CTRL  = 3'b001,
        ST_WORD  = 3'b010,
        ST_WDATA = 3'b011,
        ST_READ  = 3'b100
    } isa_state_t;

endpackage

// [rtl/isa_ram.sv]
// General-purpose RAM with registered read data and no reset.
`timescale 1ns/1ns
module isa_ram (
    input  wire logic                       clk_sys,
    input  wire logic                       wr_en,
    input  wire logic [isa_pkg::RAM_AW-1:0] addr,
    input  wire logic [7:0]                 wr_data,
    output logic      [7:0]                 rd_data_reg
);

    logic [7:0] mem_reg [isa_pkg::RAM_DEPTH];

    // Contents survive reset on purpose; nothing clears the array.
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem_reg[addr] <= wr_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        rd_data_reg <= mem_reg[addr];
    end

endmodule // isa_ram

// [rtl/isa_access.sv]
// Two-wire slave giving access to calendar registers and general RAM.
`timescale 1ns/1ns
module isa_access (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       scl_clk,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic       on_backup,
    input  wire logic [7:0] cal_rd_data,
    input  wire logic [7:0] cal_rd_mask,
    output logic      [4:0] cal_addr,
    output logic      [7:0] cal_wr_data,
    output logic            cal_wr_en
);

    // ------------------------------------------------------------------
    // Link clock domain
    // ------------------------------------------------------------------
    // Each rising bus clock toggles a flag and holds the sampled data bit
    // stable until the next rising edge, which is long after it crossed.
    logic link_tgl_reg;
    logic link_bit_reg;

    always_ff @(posedge scl_clk or negedge reset_n) begin
        if (!reset_n) begin
            link_tgl_reg <= 1'b0;
            link_bit_reg <= 1'b1;
        end else begin
            link_tgl_reg <= ~link_tgl_reg;
            link_bit_reg <= sda_i;
        end
    end

    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    logic scl_meta_reg, scl_s_reg, scl_d_reg;
    logic sda_meta_reg, sda_s_reg, sda_d_reg;
    logic tgl_meta_reg, tgl_s_reg, tgl_d_reg;
    logic bit_meta_reg, bit_s_reg;
    logic bkp_meta_reg, bkp_s_reg;
    logic bit_evt_reg;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            scl_meta_reg <= 1'b1;
            scl_s_reg    <= 1'b1;
            scl_d_reg    <= 1'b1;
            sda_meta_reg <= 1'b1;
            sda_s_reg    <= 1'b1;
            sda_d_reg    <= 1'b1;
            tgl_meta_reg <= 1'b0;
            tgl_s_reg    <= 1'b0;
            tgl_d_reg    <= 1'b0;
            bit_meta_reg <= 1'b1;
            bit_s_reg    <= 1'b1;
            bkp_meta_reg <= 1'b0;
            bkp_s_reg    <= 1'b0;
            bit_evt_reg  <= 1'b0;
        end else begin
            scl_meta_reg <= scl_clk;
            scl_s_reg    <= scl_meta_reg;
            scl_d_reg    <= scl_s_reg;
            sda_meta_reg <= sda_i;
            sda_s_reg    <= sda_meta_reg;
            sda_d_reg    <= sda_s_reg;
            tgl_meta_reg <= link_tgl_reg;
            tgl_s_reg    <= tgl_meta_reg;
            tgl_d_reg    <= tgl_s_reg;
            bit_meta_reg <= link_bit_reg;
            bit_s_reg    <= bit_meta_reg;
            bkp_meta_reg <= on_backup;
            bkp_s_reg    <= bkp_meta_reg;
            // Delayed one cycle so the data bit has surely settled.
            bit_evt_reg  <= tgl_s_reg ^ tgl_d_reg;
        end
    end

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    isa_pkg::isa_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [6:0] ptr_reg;
    logic       ack_pend_reg;
    logic       sda_o_reg;
    logic       sda_oe_reg;
    logic [4:0] cal_addr_reg;
    logic [7:0] cal_wr_data_reg;
    logic       cal_wr_en_reg;
    logic [7:0] ram_rd_data;

    logic       start_det;
    logic       stop_det;
    logic       scl_fall;
    logic       evt_ok;
    logic       byte_done;
    logic       ack_evt;
    logic [7:0] rx_byte;
    logic       id_match;
    logic       addr_ok;
    logic       wr_evt;
    logic       load_evt;
    logic       ptr_step;
    logic       in_cal;
    logic [7:0] rd_byte;
    logic [6:0] ptr_next;
    logic       ram_we;
    logic [isa_pkg::RAM_AW-1:0] ram_addr;

    assign start_det = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
    assign stop_det  = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;
    assign scl_fall  = scl_d_reg & ~scl_s_reg;
    assign evt_ok    = ~bkp_s_reg & ~start_det & ~stop_det;
    assign rx_byte   = {shift_reg[6:0], bit_s_reg};
    assign byte_done = evt_ok & bit_evt_reg & (state_reg != isa_pkg::ST_IDLE)
                     & (bit_cnt_reg == isa_pkg::BIT_LAST);
    assign ack_evt   = evt_ok & bit_evt_reg & (state_reg != isa_pkg::ST_IDLE)
                     & (bit_cnt_reg == isa_pkg::ACK_SLOT);
    assign id_match  = (rx_byte[7:1] == isa_pkg::SLAVE_ID);
    assign addr_ok   = (rx_byte <= {1'b0, isa_pkg::RAM_LAST});
    assign wr_evt    = byte_done & (state_reg == isa_pkg::ST_WDATA);
    assign load_evt  = ack_evt & (state_reg == isa_pkg::ST_READ) & ~bit_s_reg;
    assign ptr_step  = wr_evt | load_evt;
    assign in_cal    = (ptr_reg <= isa_pkg::CAL_LAST);
    // Unimplemented calendar bits are masked to zero.
    assign rd_byte   = in_cal ? (cal_rd_data & cal_rd_mask) : ram_rd_data;
    // The RAM path has no dependence on calendar update activity.
    assign ram_we    = wr_evt & ~in_cal;
    assign ram_addr  = isa_pkg::RAM_AW'(ptr_reg - isa_pkg::RAM_FIRST);

    // Pointer advance wraps within the area it is in.
    always_comb begin
        if (ptr_reg == isa_pkg::CAL_LAST) begin
            ptr_next = isa_pkg::CAL_FIRST;
        end else if (ptr_reg == isa_pkg::RAM_LAST) begin
            ptr_next = isa_pkg::RAM_FIRST;
        end else begin
            ptr_next = ptr_reg + 7'h01;
        end
    end

    // ------------------------------------------------------------------
    // Transfer sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_reg   <= isa_pkg::ST_IDLE;
            bit_cnt_reg <= isa_pkg::BIT_FIRST;
        end else if (bkp_s_reg) begin
            state_reg   <= isa_pkg::ST_IDLE;
            bit_cnt_reg <= isa_pkg::BIT_FIRST;
        end else if (start_det) begin
            state_reg   <= isa_pkg::ST_CTRL;
            bit_cnt_reg <= isa_pkg::BIT_FIRST;
        end else if (stop_det) begin
            state_reg   <= isa_pkg::ST_IDLE;
            bit_cnt_reg <= isa_pkg::BIT_FIRST;
        end else if (bit_evt_reg && state_reg != isa_pkg::ST_IDLE) begin
            if (bit_cnt_reg == isa_pkg::ACK_SLOT) begin
                bit_cnt_reg <= isa_pkg::BIT_FIRST;
                // A missing master acknowledge ends the read.
                if (state_reg == isa_pkg::ST_READ && bit_s_reg) begin
                    state_reg <= isa_pkg::ST_IDLE;
                end
            end else begin
                bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
            end
            if (bit_cnt_reg == isa_pkg::BIT_LAST) begin
                unique case (state_reg)
                    isa_pkg::ST_CTRL: begin
                        if (!id_match) begin
                            state_reg <= isa_pkg::ST_IDLE;
                        end else if (rx_byte[0]) begin
                            state_reg <= isa_pkg::ST_READ;
                        end else begin
                            state_reg <= isa_pkg::ST_WORD;
                        end
                    end
                    isa_pkg::ST_WORD: begin
                        if (addr_ok) begin
                            state_reg <= isa_pkg::ST_WDATA;
                        end else begin
                            state_reg <= isa_pkg::ST_IDLE;
                        end
                    end
                    isa_pkg::ST_IDLE,
                    isa_pkg::ST_WDATA,
                    isa_pkg::ST_READ: begin
                        state_reg <= state_reg;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            shift_reg <= 8'h00;
        end else if (bit_evt_reg) begin
            shift_reg <= rx_byte;
        end
    end

    // Acknowledge decision taken when the eighth bit arrives.
    always_ff @(posedge clk_sys) begin
        if (!reset_n || bkp_s_reg || start_det || stop_det) begin
            ack_pend_reg <= 1'b0;
        end else if (byte_done) begin
            unique case (state_reg)
                isa_pkg::ST_CTRL:  ack_pend_reg <= id_match;
                isa_pkg::ST_WORD:  ack_pend_reg <= addr_ok;
                isa_pkg::ST_WDATA: ack_pend_reg <= 1'b1;
                isa_pkg::ST_IDLE,
                isa_pkg::ST_READ:  ack_pend_reg <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Address pointer and stores
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ptr_reg <= isa_pkg::PTR_RESET;
        end else if (byte_done && addr_ok
                     && state_reg == isa_pkg::ST_WORD) begin
            ptr_reg <= rx_byte[6:0];
        end else if (ptr_step) begin
            // Always the location after the last one touched.
            ptr_reg <= ptr_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cal_wr_en_reg   <= 1'b0;
            cal_wr_data_reg <= 8'h00;
            cal_addr_reg    <= 5'h00;
        end else begin
            cal_wr_en_reg   <= wr_evt & in_cal;
            cal_wr_data_reg <= rx_byte;
            cal_addr_reg    <= ptr_reg[4:0];
        end
    end

    isa_ram u_ram (
        .clk_sys     (clk_sys),
        .wr_en       (ram_we),
        .addr        (ram_addr),
        .wr_data     (rx_byte),
        .rd_data_reg (ram_rd_data)
    );

    // ------------------------------------------------------------------
    // Transmit and line drive
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            tx_reg <= 8'hFF;
        end else if (load_evt) begin
            tx_reg <= rd_byte;
        end else if (evt_ok && bit_evt_reg
                     && bit_cnt_reg < isa_pkg::ACK_SLOT) begin
            tx_reg <= {tx_reg[6:0], 1'b1};
        end
    end

    // The line is driven only from a bus clock fall; backup, start or stop release it at once.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sda_oe_reg <= 1'b0;
        end else if (!evt_ok) begin
            sda_oe_reg <= 1'b0;
        end else if (scl_fall) begin
            if (bit_cnt_reg == isa_pkg::ACK_SLOT) begin
                sda_oe_reg <= ack_pend_reg;
            end else if (state_reg == isa_pkg::ST_READ) begin
                sda_oe_reg <= ~tx_reg[7];
            end else begin
                sda_oe_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sda_o_reg <= 1'b0;
        end else begin
            sda_o_reg <= 1'b0;
        end
    end

    assign sda_o       = sda_o_reg;
    assign sda_oe      = sda_oe_reg;
    assign cal_addr    = cal_addr_reg;
    assign cal_wr_data = cal_wr_data_reg;
    assign cal_wr_en   = cal_wr_en_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_start_seen;
        start_det && !bkp_s_reg;
    endsequence

    sequence s_data_ack_slot;
        scl_fall && evt_ok && bit_cnt_reg == isa_pkg::ACK_SLOT
            && state_reg == isa_pkg::ST_WDATA;
    endsequence

    property p_start_ctrl;
        @(posedge clk_sys) disable iff (!reset_n)
        s_start_seen |=> state_reg == isa_pkg::ST_CTRL
            && bit_cnt_reg == isa_pkg::BIT_FIRST;
    endproperty
    a_start_ctrl: assert property (p_start_ctrl)
        else $error("start did not arm control byte reception");

    property p_ctrl_reject;
        @(posedge clk_sys) disable iff (!reset_n)
        (byte_done && state_reg == isa_pkg::ST_CTRL && !id_match)
            |=> state_reg == isa_pkg::ST_IDLE && !ack_pend_reg;
    endproperty
    a_ctrl_reject: assert property (p_ctrl_reject)
        else $error("foreign control byte was not ignored");

    property p_bad_addr;
        @(posedge clk_sys) disable iff (!reset_n)
        (byte_done && state_reg == isa_pkg::ST_WORD && !addr_ok)
            |=> state_reg == isa_pkg::ST_IDLE && $stable(ptr_reg)
                && !ack_pend_reg;
    endproperty
    a_bad_addr: assert property (p_bad_addr)
        else $error("out of range address was accepted");

    property p_wrap_cal;
        @(posedge clk_sys) disable iff (!reset_n)
        (ptr_step && ptr_reg == isa_pkg::CAL_LAST)
            |=> ptr_reg == isa_pkg::CAL_FIRST;
    endproperty
    a_wrap_cal: assert property (p_wrap_cal)
        else $error("pointer did not wrap inside calendar area");

    property p_wrap_ram;
        @(posedge clk_sys) disable iff (!reset_n)
        (ptr_step && ptr_reg == isa_pkg::RAM_LAST)
            |=> ptr_reg == isa_pkg::RAM_FIRST;
    endproperty
    a_wrap_ram: assert property (p_wrap_ram)
        else $error("pointer did not wrap inside RAM area");

    property p_ptr_range;
        @(posedge clk_sys) disable iff (!reset_n)
        ptr_reg <= isa_pkg::RAM_LAST;
    endproperty
    a_ptr_range: assert property (p_ptr_range)
        else $error("pointer left the mapped range");

    property p_backup_quiet;
        @(posedge clk_sys) disable iff (!reset_n)
        bkp_s_reg |=> !sda_oe_reg && state_reg == isa_pkg::ST_IDLE;
    endproperty
    a_backup_quiet: assert property (p_backup_quiet)
        else $error("bus answered while on backup supply");

    property p_cal_write;
        @(posedge clk_sys) disable iff (!reset_n)
        (wr_evt && in_cal) |=> cal_wr_en_reg
            && cal_addr_reg == $past(ptr_reg[4:0])
            && cal_wr_data_reg == $past(rx_byte);
    endproperty
    a_cal_write: assert property (p_cal_write)
        else $error("calendar store missing or misaddressed");

    property p_data_ack;
        @(posedge clk_sys) disable iff (!reset_n)
        s_data_ack_slot |=> sda_oe_reg;
    endproperty
    a_data_ack: assert property (p_data_ack)
        else $error("data byte was not acknowledged");

    property p_read_load;
        @(posedge clk_sys) disable iff (!reset_n)
        load_evt |=> tx_reg == $past(rd_byte) && ptr_reg == $past(ptr_next);
    endproperty
    a_read_load: assert property (p_read_load)
        else $error("read byte or pointer advance wrong");

endmodule // isa_access

// [verification/isa_master.sv]
// Behavioural two-wire bus master that drives the link side of the block.
`timescale 1ns/1ns
module isa_master (
    output logic      scl_clk,
    output logic      sda_pull,
    input  wire logic sda_line
);
    // ------------------------------------------------------------------
    // Bit and byte level
    // ------------------------------------------------------------------
    // The clock stands high between frames and data changes mid-low.
    initial begin
        scl_clk  = 1'b1;
        sda_pull = 1'b0;
    end

    // A start works from idle and as a repeated start after an ack slot.
    task automatic start_cond();
        #43 sda_pull = 1'b0;
        #40 scl_clk = 1'b1;
        #40 sda_pull = 1'b1;
        #40 scl_clk = 1'b0;
    endtask

    task automatic stop_cond();
        #40 sda_pull = 1'b1;
        #40 scl_clk = 1'b1;
        #40 sda_pull = 1'b0;
        #80;
    endtask

    task automatic put_bit(input logic b);
        #40 sda_pull = ~b;
        #40 scl_clk = 1'b1;
        #80 scl_clk = 1'b0;
    endtask

    task automatic get_bit(output logic b);
        #40 sda_pull = 1'b0;
        #40 scl_clk = 1'b1;
        #40 b = sda_line;
        #40 scl_clk = 1'b0;
    endtask

    // Sends most significant bit first, then samples the ack slot.
    task automatic put_byte(input logic [7:0] d,
                            output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(b);
        ack = ~b;
    endtask

    // Low after the byte asks for the next one; high ends the read.
    task automatic get_byte(input logic last,
                            output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            get_bit(d[i]);
        end
        put_bit(last);
    endtask
endmodule // isa_master

// [verification/i2c_register_sram_access_tb_top.sv]
// Self-checking testbench for the two-wire register and RAM access block.
`timescale 1ns/1ns
module i2c_register_sram_access_tb_top;
    logic       clk_sys;
    logic       reset_n;
    logic       on_backup;
    logic       scl_clk;
    logic       m_pull;
    wire logic  sda_line;
    logic       sda_o;
    logic       sda_oe;
    logic [7:0] cal_rd_data;
    logic [7:0] cal_rd_mask;
    logic [4:0] cal_addr;
    logic [7:0] cal_wr_data;
    logic       cal_wr_en;
    logic [7:0] cal_mem [32];
    int         n_errors;
    int         samples_checked;

    // ------------------------------------------------------------------
    // Wire, calendar model and instances
    // ------------------------------------------------------------------
    // The data line has a pull-up, so a released line reads high.
    assign sda_line    = ~(m_pull | (sda_oe & ~sda_o));
    assign cal_rd_data = cal_mem[cal_addr];
    assign cal_rd_mask = (cal_addr == 5'h1F) ? 8'h00 : 8'h7F;

    always #5 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        if (cal_wr_en === 1'b1) begin
            cal_mem[cal_addr] <= cal_wr_data;
        end
    end

    isa_access uut (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .scl_clk     (scl_clk),
        .sda_i       (sda_line),
        .sda_o       (sda_o),
        .sda_oe      (sda_oe),
        .on_backup   (on_backup),
        .cal_rd_data (cal_rd_data),
        .cal_rd_mask (cal_rd_mask),
        .cal_addr    (cal_addr),
        .cal_wr_data (cal_wr_data),
        .cal_wr_en   (cal_wr_en)
    );

    isa_master u_master (
        .scl_clk  (scl_clk),
        .sda_pull (m_pull),
        .sda_line (sda_line)
    );

    // ------------------------------------------------------------------
    // Checking and bus helpers
    // ------------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                        input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_ack(input logic got, input logic exp,
                           input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s ack %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic set_ptr(input logic [6:0] a);
        logic ack;
        u_master.start_cond();
        u_master.put_byte(8'hDE, ack);
        chk_ack(ack, 1'b1, "write control");
        u_master.put_byte({1'b0, a}, ack);
        chk_ack(ack, 1'b1, "address");
    endtask

    task automatic wr_seq(input logic [6:0] a, input logic [7:0] d [3],
                          input int n);
        logic ack;
        set_ptr(a);
        for (int i = 0; i < n; i++) begin
            u_master.put_byte(d[i], ack);
            chk_ack(ack, 1'b1, "data");
        end
        u_master.stop_cond();
    endtask

    task automatic rd_seq(input logic [6:0] a, input logic [7:0] e [3],
                          input int n);
        logic       ack;
        logic [7:0] d;
        set_ptr(a);
        u_master.start_cond();
        u_master.put_byte(8'hDF, ack);
        chk_ack(ack, 1'b1, "read control");
        for (int i = 0; i < n; i++) begin
            u_master.get_byte(i == n - 1, d);
            chk8(d, e[i], "read data");
        end
        u_master.stop_cond();
    endtask

    task automatic cur_rd(input logic [7:0] e);
        logic       ack;
        logic [7:0] d;
        u_master.start_cond();
        u_master.put_byte(8'hDF, ack);
        chk_ack(ack, 1'b1, "read control");
        u_master.get_byte(1'b1, d);
        u_master.stop_cond();
        chk8(d, e, "current read");
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_ram_seq();
        wr_seq(7'h5E, '{8'hA1, 8'hB2, 8'hC3}, 3);
        rd_seq(7'h5E, '{8'hA1, 8'hB2, 8'hC3}, 3);
        $display("test ram_seq done");
    endtask

    task automatic t_byte_write();
        wr_seq(7'h5F, '{8'h77, 8'h00, 8'h00}, 1);
        cur_rd(8'hC3);
        rd_seq(7'h5F, '{8'h77, 8'h00, 8'h00}, 1);
        cur_rd(8'hC3);
        $display("test byte_write done");
    endtask

    task automatic t_cal();
        wr_seq(7'h1E, '{8'hC4, 8'hD5, 8'hE6}, 3);
        rd_seq(7'h1E, '{8'h44, 8'h00, 8'h66}, 3);
        $display("test calendar done");
    endtask

    task automatic t_bad_addr();
        logic ack;
        rd_seq(7'h5E, '{8'hA1, 8'h00, 8'h00}, 1);
        u_master.start_cond();
        u_master.put_byte(8'hDE, ack);
        chk_ack(ack, 1'b1, "write control");
        u_master.put_byte(8'h60, ack);
        chk_ack(ack, 1'b0, "high address");
        u_master.put_byte(8'h99, ack);
        chk_ack(ack, 1'b0, "high data");
        u_master.stop_cond();
        cur_rd(8'h77);
        $display("test bad_addr done");
    endtask

    task automatic t_foreign();
        logic       ack;
        logic [7:0] ctl [3];
        ctl = '{8'hDC, 8'h5E, 8'hFE};
        for (int i = 0; i < 3; i++) begin
            u_master.start_cond();
            u_master.put_byte(ctl[i], ack);
            chk_ack(ack, 1'b0, "foreign control");
            u_master.stop_cond();
        end
        $display("test foreign done");
    endtask

    task automatic t_backup();
        logic ack;
        @(negedge clk_sys);
        on_backup = 1'b1;
        repeat (10) @(negedge clk_sys);
        u_master.start_cond();
        u_master.put_byte(8'hDE, ack);
        chk_ack(ack, 1'b0, "backup control");
        u_master.stop_cond();
        @(negedge clk_sys);
        on_backup = 1'b0;
        repeat (10) @(negedge clk_sys);
        rd_seq(7'h5E, '{8'hA1, 8'h77, 8'hC3}, 3);
        $display("test backup done");
    endtask

    initial begin
        clk_sys         = 1'b0;
        reset_n         = 1'b1;
        on_backup       = 1'b0;
        n_errors        = 0;
        samples_checked = 0;
        for (int i = 0; i < 32; i++) begin
            cal_mem[i] = 8'h00;
        end
        // The link flops clear only on a real falling edge of reset.
        #1 reset_n = 1'b0;
        repeat (8) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (6) @(negedge clk_sys);
        t_ram_seq();
        t_byte_write();
        t_cal();
        t_bad_addr();
        t_foreign();
        t_backup();
        results();
    end

    initial begin
        repeat (60000) @(posedge clk_sys);
        n_errors++;
        $display("MISMATCH %0t run timed out", $time);
        results();
    end
endmodule // i2c_register_sram_access_tb_top
